/* verilog/cache_ctl_pkg.sv */
// constants for the cache control-space command sequencer
package cache_ctl_pkg;
    localparam logic [2:0] FC_CONTROL = 3'h3;
    localparam logic [3:0] OP_TAG = 4'h8;
    localparam logic [3:0] OP_DATA = 4'h9;
    localparam logic [3:0] OP_FLUSH = 4'hA;
    localparam logic [3:0] OP_COPY_RD = 4'hB;
    localparam logic [3:0] OP_COPY_WR = 4'hC;
    localparam int FLUSH_CTX_BIT = 0;
    localparam int FLUSH_PAGE_BIT = 1;
    localparam int FLUSH_SEG_BIT = 2;
    localparam int TAG_VALID_BIT = 31;
    localparam int TAG_MOD_BIT = 30;
    localparam int TAG_VA_HI = 27;
    localparam int TAG_VA_LO = 14;
    localparam int TAG_WPROT_BIT = 13;
    localparam int TAG_SUP_BIT = 12;
    localparam int TAG_CTX_HI = 10;
    localparam int TAG_CTX_LO = 8;
    localparam logic [3:0] FLUSH_BLOCKS_LAST = 4'hF;
    localparam logic [3:0] BLOCK_NIBBLE_START = 4'h0;
    localparam logic [1:0] COPY_WORDS_LAST = 2'h3;
    localparam logic [31:0] TAG_RESET = 32'h0000_0000;
    localparam logic [31:0] DATA_RESET = 32'h0000_0000;
endpackage

/* verilog/cache_ram.sv */
// single-port cache array with registered read data
`timescale 1ns/100ps
module cache_ram
    import cache_ctl_pkg::*;
#(
    parameter int AW = 10,
    parameter int DW = 32
) (
    input wire logic mclk_i,
    input wire logic ce_i,
    input wire logic we_i,
    input wire logic [AW-1:0] addr_i,
    input wire logic [DW-1:0] wdata_i,
    input wire logic [DW/8-1:0] be_i,
    output logic [DW-1:0] rdata_o
);
    logic [DW-1:0] mem [2**AW];
    logic [DW-1:0] rdata_reg;

    // no reset on the array: software clears valid bits itself
    always_ff @(posedge mclk_i) begin
        if (ce_i) begin
            for (int i = 0; i < DW/8; i++) begin
                if (we_i && be_i[i]) begin
                    mem[addr_i][i*8 +: 8] <= wdata_i[i*8 +: 8];
                end
            end
            rdata_reg <= mem[addr_i];
        end
    end
    assign rdata_o = rdata_reg;
endmodule

/* verilog/block_match.sv */
// flush match test of one block's tag word
`timescale 1ns/100ps
module block_match
    import cache_ctl_pkg::*;
#(
    parameter int SEG_LO = 17
) (
    input wire logic [31:0] tag_i,
    input wire logic [31:0] cmd_addr_i,
    input wire logic [3:0] mode_i,
    input wire logic [2:0] context_i,
    output logic hit_o
);
    logic ctx_eq;
    logic sup;
    logic own;
    always_comb begin
        ctx_eq = tag_i[TAG_CTX_HI:TAG_CTX_LO] == context_i;
        sup = tag_i[TAG_SUP_BIT];
        own = sup || ctx_eq;
        hit_o = 1'b0;
        if (tag_i[TAG_VALID_BIT]) begin
            if (mode_i[FLUSH_CTX_BIT]) begin
                hit_o = !sup && ctx_eq; // see RULE_10
            end else if (mode_i[FLUSH_PAGE_BIT]) begin
                // low page bits index the set, so only tag bits compare
                hit_o = own && (tag_i[TAG_VA_HI:TAG_VA_LO]
                    == cmd_addr_i[TAG_VA_HI:TAG_VA_LO]); // see RULE_12
            end else if (mode_i[FLUSH_SEG_BIT]) begin
                hit_o = own && (tag_i[TAG_VA_HI:SEG_LO]
                    == cmd_addr_i[TAG_VA_HI:SEG_LO]); // see RULE_13
            end
        end
    end
endmodule

/* verilog/cache_ctl_seq.sv */
// decoder and sequencer for cache control-space commands
//
// Summary of operation
// RULE_01 - only processor control-space cycles decode commands
// RULE_02 - flush steps block nibble 0 through 15
// RULE_03 - matching blocks written back if modified, invalidated
// RULE_04 - no protection check on control commands
// RULE_05 - op 1000 reads or writes tag word
// RULE_06 - tag word layout: valid, modified, VA, protection, context
// RULE_07 - zeroed valid bits make blocks invalid
// RULE_08 - byte, word, long transfers; no errors, no interrupts
// RULE_09 - op 1001 accesses data, no tag check
// RULE_10 - context flush: user blocks, context equal
// RULE_11 - op 1010 flush, set index above nibble
// RULE_12 - page flush: page tag match plus owner
// RULE_13 - segment flush: segment match plus owner
// RULE_14 - flushes never update MMU usage bits
// RULE_15 - invalid write-back translation raises error pulse
// RULE_16 - software flushes before unmapping in MMU
// RULE_17 - copy read: hit check, write back, buffer address
// RULE_18 - copy read: 16 bytes, accessed bit on miss
// RULE_19 - copy write: invalidate, read buffered, write destination
// RULE_20 - copy write sets accessed and modified bits
// RULE_21 - software must not rely on intervening stores
// RULE_22 - flush cycle acknowledged after all sixteen blocks
`timescale 1ns/100ps
module cache_ctl_seq
    import cache_ctl_pkg::*;
#(
    parameter int IDX_W = 10
) (
    input wire logic mclk_i,
    input wire logic srst_i,
    input wire logic ce_i,
    // processor cycle
    input wire logic cyc_i,
    input wire logic [2:0] fc_i,
    input wire logic we_i,
    input wire logic [31:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic [3:0] be_i,
    input wire logic [2:0] context_i,
    output logic ack_o,
    output logic [31:0] rdata_o,
    // mmu translation, protection check never requested
    output logic xlat_req_o,
    output logic [31:0] xlat_vaddr_o,
    output logic xlat_set_acc_o,
    output logic xlat_set_mod_o,
    input wire logic xlat_done_i,
    input wire logic xlat_ok_i,
    input wire logic [31:0] xlat_paddr_i,
    // memory block transfer
    output logic mem_req_o,
    output logic mem_we_o,
    output logic [31:0] mem_addr_o,
    input wire logic mem_done_i,
    // single-cycle error event
    output logic wb_err_o
);
    localparam int TOP = IDX_W + 3;

    typedef enum {
        S_IDLE, S_RD_WAIT, S_ACK, S_FL_READ, S_FL_CHECK, S_WB_XLAT,
        S_WB_MEM, S_CP_XLAT, S_CP_READ, S_CP_CHECK, S_CP_MEM,
        S_CPW_XLAT, S_CPW_RD, S_CPW_WR
    } state_e;

    state_e state_reg, state_next;
    logic [31:0] cmd_reg, cmd_next;
    logic [3:0] mode_reg, mode_next;
    logic [3:0] blk_reg, blk_next;
    logic [31:0] copy_buf_reg, copy_buf_next;
    logic [31:0] dest_reg, dest_next;
    logic [31:0] rdata_reg, rdata_next;
    logic ack_reg, ack_next;
    logic xreq_reg, xreq_next;
    logic [31:0] xva_reg, xva_next;
    logic xacc_reg, xacc_next;
    logic xmod_reg, xmod_next;
    logic mreq_reg, mreq_next;
    logic mwe_reg, mwe_next;
    logic [31:0] maddr_reg, maddr_next;
    logic err_reg, err_next;

    logic tag_we, data_we;
    logic [IDX_W-1:0] tag_idx;
    logic [IDX_W+1:0] data_idx;
    logic [31:0] tag_wdata;
    logic [3:0] tag_be;
    logic [31:0] tag_q, data_q;
    logic hit;
    logic ctl_cyc;

    cache_ram #(.AW(IDX_W), .DW(32)) u_tags (
        .mclk_i(mclk_i),
        .ce_i(ce_i),
        .we_i(tag_we),
        .addr_i(tag_idx),
        .wdata_i(tag_wdata),
        .be_i(tag_be),
        .rdata_o(tag_q)
    );

    cache_ram #(.AW(IDX_W + 2), .DW(32)) u_data (
        .mclk_i(mclk_i),
        .ce_i(ce_i),
        .we_i(data_we),
        .addr_i(data_idx),
        .wdata_i(wdata_i),
        .be_i(be_i),
        .rdata_o(data_q)
    );

    block_match #(.SEG_LO(17)) u_match (
        .tag_i(tag_q),
        .cmd_addr_i(cmd_reg),
        .mode_i(mode_reg),
        .context_i(context_i),
        .hit_o(hit)
    );

    // cycles of other function codes belong to other decoders
    assign ctl_cyc = cyc_i && fc_i == FC_CONTROL; // see RULE_01

    always_comb begin
        state_next = state_reg;
        cmd_next = cmd_reg;
        mode_next = mode_reg;
        blk_next = blk_reg;
        copy_buf_next = copy_buf_reg;
        dest_next = dest_reg;
        rdata_next = rdata_reg;
        ack_next = 1'b0;
        xreq_next = xreq_reg;
        xva_next = xva_reg;
        xacc_next = 1'b0;
        xmod_next = 1'b0;
        mreq_next = mreq_reg;
        mwe_next = mwe_reg;
        maddr_next = maddr_reg;
        err_next = 1'b0;
        tag_we = 1'b0;
        data_we = 1'b0;
        tag_idx = addr_i[TOP:4];
        data_idx = addr_i[TOP:2];
        tag_wdata = wdata_i;
        tag_be = be_i;
        unique case (state_reg)
            S_IDLE: begin
                // the ack cycle must not take the still-held request again
                if (ctl_cyc && !ack_reg) begin
                    cmd_next = addr_i;
                    unique case (addr_i[31:28])
                        OP_TAG: begin
                            // see RULE_05, RULE_06, RULE_07, RULE_08
                            tag_we = we_i;
                            state_next = we_i ? S_ACK : S_RD_WAIT;
                        end
                        OP_DATA: begin
                            data_we = we_i; // see RULE_09, RULE_08
                            state_next = we_i ? S_ACK : S_RD_WAIT;
                        end
                        OP_FLUSH: begin
                            mode_next = wdata_i[3:0]; // see RULE_03
                            blk_next = BLOCK_NIBBLE_START; // see RULE_02
                            state_next = S_FL_READ; // see RULE_11
                        end
                        OP_COPY_RD: begin
                            xreq_next = 1'b1; // see RULE_04
                            xva_next = addr_i;
                            state_next = S_CP_XLAT;
                        end
                        OP_COPY_WR: begin
                            xreq_next = 1'b1;
                            xva_next = addr_i;
                            state_next = S_CPW_XLAT;
                        end
                        default: state_next = S_ACK;
                    endcase
                end
            end
            S_RD_WAIT: begin
                rdata_next = cmd_reg[31:28] == OP_TAG ? tag_q : data_q;
                state_next = S_ACK;
            end
            S_ACK: begin
                ack_next = 1'b1;
                state_next = S_IDLE;
            end
            S_FL_READ: begin
                tag_idx = {cmd_reg[TOP:8], blk_reg};
                state_next = S_FL_CHECK;
            end
            S_FL_CHECK: begin
                tag_idx = {cmd_reg[TOP:8], blk_reg};
                if (hit && tag_q[TAG_MOD_BIT]) begin
                    // translation only; usage bits untouched
                    xreq_next = 1'b1; // see RULE_14
                    xva_next = {4'h0, tag_q[TAG_VA_HI:TAG_VA_LO],
                        cmd_reg[TAG_VA_LO-1:8], blk_reg, 4'h0};
                    state_next = S_WB_XLAT;
                end else begin
                    if (hit) begin
                        tag_we = 1'b1; // see RULE_03
                        tag_wdata = TAG_RESET;
                        tag_be = 4'hF;
                    end
                    blk_next = blk_reg + 4'h1;
                    // see RULE_22
                    state_next = blk_reg == FLUSH_BLOCKS_LAST ?
                        S_ACK : S_FL_READ;
                end
            end
            S_WB_XLAT: begin
                if (xlat_done_i) begin
                    xreq_next = 1'b0;
                    if (xlat_ok_i) begin
                        mreq_next = 1'b1;
                        mwe_next = 1'b1;
                        maddr_next = xlat_paddr_i;
                        state_next = S_WB_MEM;
                    end else begin
                        err_next = 1'b1; // see RULE_15
                        state_next = S_WB_MEM;
                    end
                end
            end
            S_WB_MEM: begin
                tag_idx = {cmd_reg[TOP:8], blk_reg};
                if (mem_done_i || !mreq_reg) begin
                    mreq_next = 1'b0;
                    tag_we = 1'b1;
                    tag_wdata = TAG_RESET;
                    tag_be = 4'hF;
                    blk_next = blk_reg + 4'h1;
                    state_next = blk_reg == FLUSH_BLOCKS_LAST ?
                        S_ACK : S_FL_READ;
                end
            end
            S_CP_XLAT: begin
                tag_idx = cmd_reg[TOP:4];
                if (xlat_done_i) begin
                    xreq_next = 1'b0;
                    copy_buf_next = xlat_paddr_i; // see RULE_17
                    state_next = S_CP_CHECK;
                end
            end
            S_CP_CHECK: begin
                tag_idx = cmd_reg[TOP:4];
                if (tag_q[TAG_VALID_BIT] && tag_q[TAG_VA_HI:TAG_VA_LO]
                    == cmd_reg[TAG_VA_HI:TAG_VA_LO]) begin
                    mreq_next = tag_q[TAG_MOD_BIT];
                    mwe_next = 1'b1;
                    maddr_next = copy_buf_reg;
                    state_next = tag_q[TAG_MOD_BIT] ? S_CP_MEM : S_ACK;
                end else begin
                    xacc_next = 1'b1; // see RULE_18
                    state_next = S_ACK;
                end
            end
            S_CP_MEM: begin
                if (mem_done_i) begin
                    mreq_next = 1'b0;
                    state_next = S_ACK;
                end
            end
            S_CPW_XLAT: begin
                tag_idx = cmd_reg[TOP:4];
                if (xlat_done_i) begin
                    xreq_next = 1'b0;
                    dest_next = xlat_paddr_i;
                    xacc_next = 1'b1; // see RULE_20
                    xmod_next = 1'b1;
                    if (tag_q[TAG_VALID_BIT] && tag_q[TAG_VA_HI:TAG_VA_LO]
                        == cmd_reg[TAG_VA_HI:TAG_VA_LO]) begin
                        tag_we = 1'b1; // see RULE_19
                        tag_wdata = TAG_RESET;
                        tag_be = 4'hF;
                    end
                    mreq_next = 1'b1;
                    mwe_next = 1'b0;
                    maddr_next = copy_buf_reg;
                    state_next = S_CPW_RD;
                end
            end
            S_CPW_RD: begin
                if (mem_done_i) begin
                    mwe_next = 1'b1;
                    maddr_next = dest_reg;
                    state_next = S_CPW_WR;
                end
            end
            S_CPW_WR: begin
                if (mem_done_i) begin
                    mreq_next = 1'b0;
                    mwe_next = 1'b0;
                    state_next = S_ACK;
                end
            end
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            state_reg <= S_IDLE;
            cmd_reg <= 32'h0000_0000;
            mode_reg <= 4'h0;
            blk_reg <= 4'h0;
            copy_buf_reg <= 32'h0000_0000;
            dest_reg <= 32'h0000_0000;
            rdata_reg <= 32'h0000_0000;
            ack_reg <= 1'b0;
            xreq_reg <= 1'b0;
            xva_reg <= 32'h0000_0000;
            xacc_reg <= 1'b0;
            xmod_reg <= 1'b0;
            mreq_reg <= 1'b0;
            mwe_reg <= 1'b0;
            maddr_reg <= 32'h0000_0000;
            err_reg <= 1'b0;
        end else if (ce_i) begin
            state_reg <= state_next;
            cmd_reg <= cmd_next;
            mode_reg <= mode_next;
            blk_reg <= blk_next;
            copy_buf_reg <= copy_buf_next;
            dest_reg <= dest_next;
            rdata_reg <= rdata_next;
            ack_reg <= ack_next;
            xreq_reg <= xreq_next;
            xva_reg <= xva_next;
            xacc_reg <= xacc_next;
            xmod_reg <= xmod_next;
            mreq_reg <= mreq_next;
            mwe_reg <= mwe_next;
            maddr_reg <= maddr_next;
            err_reg <= err_next;
        end
    end

    assign ack_o = ack_reg;
    assign rdata_o = rdata_reg;
    assign xlat_req_o = xreq_reg;
    assign xlat_vaddr_o = xva_reg;
    assign xlat_set_acc_o = xacc_reg;
    assign xlat_set_mod_o = xmod_reg;
    assign mem_req_o = mreq_reg;
    assign mem_we_o = mwe_reg;
    assign mem_addr_o = maddr_reg;
    assign wb_err_o = err_reg;
endmodule

/* bench/cache_ctl_seq_sva.sv */
// port-level assertions for the cache command sequencer
`timescale 1ns/100ps
module cache_ctl_seq_sva
    import cache_ctl_pkg::*;
(
    input wire logic mclk_i,
    input wire logic srst_i,
    input wire logic ce_i,
    input wire logic cyc_i,
    input wire logic [2:0] fc_i,
    input wire logic we_i,
    input wire logic [31:0] addr_i,
    input wire logic ack_o,
    input wire logic xlat_req_o,
    input wire logic xlat_set_acc_o,
    input wire logic xlat_set_mod_o,
    input wire logic xlat_done_i,
    input wire logic mem_req_o,
    input wire logic mem_we_o,
    input wire logic [31:0] mem_addr_o,
    input wire logic mem_done_i,
    input wire logic wb_err_o
);
    logic busy_reg, busy_next, fl_reg, fl_next, take;
    logic [7:0] cnt_reg, cnt_next;
    // our own view of the pending cycle, so latency is tied to the take
    assign take = cyc_i && fc_i == FC_CONTROL && ce_i && !busy_reg;
    always_comb begin
        busy_next = take ? 1'h1 : (ack_o ? 1'h0 : busy_reg);
        fl_next = take ? addr_i[31:28] == OP_FLUSH : (ack_o ? 1'h0 : fl_reg);
        cnt_next = take ? 8'h00 : cnt_reg + {7'h00, cnt_reg != 8'hFF};
    end
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            busy_reg <= 1'h0;
            fl_reg <= 1'h0;
            cnt_reg <= 8'h00;
        end else begin
            busy_reg <= busy_next;
            fl_reg <= fl_next;
            cnt_reg <= cnt_next;
        end
    end
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (srst_i);
    ack_cyc_a: assert property (ack_o |-> busy_reg && cyc_i)
        else $error("ack without a pending control cycle");
    ack_pulse_a: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    tag_wr_lat_a: assert property (
        take && we_i && addr_i[31:28] == OP_TAG |-> ##1 !ack_o ##1 ack_o)
        else $error("tag write ack not two cycles after take");
    data_rd_lat_a: assert property (
        take && !we_i && addr_i[31:28] == OP_DATA |-> ##2 !ack_o ##1 ack_o)
        else $error("data read ack not three cycles after take");
    flush_len_a: assert property (
        ack_o && fl_reg |-> cnt_reg >= 8'h1F)
        else $error("flush acked before all blocks were walked");
    flush_usage_a: assert property (
        fl_reg |-> !xlat_set_acc_o && !xlat_set_mod_o)
        else $error("flush touched usage bits");
    flush_wb_a: assert property (
        fl_reg && mem_req_o |-> mem_we_o)
        else $error("flush issued a memory read");
    err_src_a: assert property (wb_err_o |-> fl_reg)
        else $error("write-back error outside a flush");
    mod_acc_a: assert property (xlat_set_mod_o |-> xlat_set_acc_o)
        else $error("modified set without accessed");
    mem_hold_a: assert property (
        mem_req_o && !mem_done_i |=> mem_req_o && $stable(mem_addr_o))
        else $error("memory request dropped or moved early");
    xlat_hold_a: assert property (
        xlat_req_o && !xlat_done_i |=> xlat_req_o)
        else $error("translation request dropped early");
    cover property (ack_o && fl_reg);
    cover property (wb_err_o);
    cover property (xlat_set_mod_o);
endmodule
bind cache_ctl_seq cache_ctl_seq_sva chk (.mclk_i(mclk_i), .srst_i(srst_i),
    .ce_i(ce_i), .cyc_i(cyc_i), .fc_i(fc_i), .we_i(we_i), .addr_i(addr_i),
    .ack_o(ack_o), .xlat_req_o(xlat_req_o), .xlat_set_acc_o(xlat_set_acc_o),
    .xlat_set_mod_o(xlat_set_mod_o), .xlat_done_i(xlat_done_i),
    .mem_req_o(mem_req_o), .mem_we_o(mem_we_o), .mem_addr_o(mem_addr_o),
    .mem_done_i(mem_done_i), .wb_err_o(wb_err_o));

/* bench/mmu_mem_model.sv */
// translation and memory responder on the far side of the sequencer
`timescale 1ns/100ps
module mmu_mem_model (
    input wire logic mclk_i,
    input wire logic xlat_req_i,
    input wire logic [31:0] xlat_vaddr_i,
    input wire logic mem_req_i,
    input wire logic bad_i,
    input wire logic [1:0] dly_i,
    output logic xlat_done_o,
    output logic xlat_ok_o,
    output logic [31:0] xlat_paddr_o,
    output logic mem_done_o
);
    logic [1:0] xc, mc;
    logic tog;
    initial begin
        {xc, mc, tog, xlat_done_o, mem_done_o} = 7'h00;
    end
    always @(posedge mclk_i) begin
        tog <= !tog;
        xc <= (xlat_req_i && !xlat_done_o && xc != dly_i) ? xc + 2'h1 : 2'h0;
        xlat_done_o <= xlat_req_i && !xlat_done_o && xc == dly_i;
        mc <= (mem_req_i && !mem_done_o && mc != dly_i) ? mc + 2'h1 : 2'h0;
        mem_done_o <= mem_req_i && !mem_done_o && mc == dly_i;
    end
    // mapping stays valid unless a test unmaps on purpose
    // answer lines toggle outside done so stale values never match
    assign xlat_ok_o = xlat_done_o ? !bad_i : tog;
    assign xlat_paddr_o = xlat_done_o ?
        {4'h0, xlat_vaddr_i[27:0] ^ 28'h010_0000} : {32{tog}};
endmodule

/* bench/cache_ctl_seq_tb_top.sv */
// self-checking bench for the cache command sequencer
`timescale 1ns/100ps
module cache_ctl_seq_tb_top
    import cache_ctl_pkg::*;
;
    localparam logic [31:0] TMASK = 32'hCFFF_F700;
    logic mclk_i, srst_i, ce_i, cyc_i, we_i, xlat_done_i, xlat_ok_i;
    logic mem_done_i, bad, ack_o, xlat_req_o, xlat_set_acc_o, hm;
    logic xlat_set_mod_o, mem_req_o, mem_we_o, wb_err_o;
    logic [2:0] fc_i, context_i;
    logic [3:0] be_i, md;
    logic [1:0] dly;
    logic [31:0] addr_i, wdata_i, rdata_o, xlat_vaddr_o, xlat_paddr_i;
    logic [31:0] mem_addr_o, rd_addr, wr_addr, rd, a, x, y, ca, da, tg[16];
    integer fails, checks, seed, cycles, acks, wrs, rds, accs, mods, errs;
    integer i, n, ew, w0, r0, e0, a0, m0;
    cache_ctl_seq #(.IDX_W(10)) dut (.mclk_i(mclk_i), .srst_i(srst_i),
        .ce_i(ce_i), .cyc_i(cyc_i), .fc_i(fc_i), .we_i(we_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .be_i(be_i),
        .context_i(context_i), .ack_o(ack_o), .rdata_o(rdata_o),
        .xlat_req_o(xlat_req_o), .xlat_vaddr_o(xlat_vaddr_o),
        .xlat_set_acc_o(xlat_set_acc_o), .xlat_set_mod_o(xlat_set_mod_o),
        .xlat_done_i(xlat_done_i), .xlat_ok_i(xlat_ok_i),
        .xlat_paddr_i(xlat_paddr_i), .mem_req_o(mem_req_o),
        .mem_we_o(mem_we_o), .mem_addr_o(mem_addr_o),
        .mem_done_i(mem_done_i), .wb_err_o(wb_err_o));
    mmu_mem_model mdl (.mclk_i(mclk_i), .xlat_req_i(xlat_req_o),
        .xlat_vaddr_i(xlat_vaddr_o), .mem_req_i(mem_req_o), .bad_i(bad),
        .dly_i(dly), .xlat_done_o(xlat_done_i), .xlat_ok_o(xlat_ok_i),
        .xlat_paddr_o(xlat_paddr_i), .mem_done_o(mem_done_i));
    initial begin
        mclk_i = 1'h0;
        forever #50 mclk_i = !mclk_i;
    end
    task automatic tally_and_finish;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // sampled before the edge's updates land
    always @(posedge mclk_i) begin
        cycles = cycles + 1;
        acks = acks + (ack_o === 1'h1);
        accs = accs + (xlat_set_acc_o === 1'h1);
        mods = mods + (xlat_set_mod_o === 1'h1);
        errs = errs + (wb_err_o === 1'h1);
        if (mem_req_o && mem_done_i && mem_we_o) begin
            wrs = wrs + 1;
            wr_addr = mem_addr_o;
        end else if (mem_req_o && mem_done_i) begin
            rds = rds + 1;
            rd_addr = mem_addr_o;
        end
        if (cycles == 40000) begin
            fails = fails + 1;
            tally_and_finish;
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks = checks + 1;
        if (seen !== exp) begin
            fails = fails + 1;
            $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one processor cycle, held until ack, released after the ack edge
    task automatic bus(input logic w, input logic [31:0] ad,
        input logic [31:0] d, input logic [3:0] b);
        int k;
        fc_i = FC_CONTROL;
        we_i = w;
        addr_i = ad;
        wdata_i = d;
        be_i = b;
        cyc_i = 1'h1;
        k = 0;
        do begin
            @(negedge mclk_i);
            k = k + 1;
        end while (ack_o !== 1'h1 && k < 3000);
        rd = rdata_o;
        @(posedge mclk_i);
        #10 cyc_i = 1'h0;
        @(posedge mclk_i);
        #10;
    endtask
    function automatic logic [31:0] merge(input logic [31:0] o,
        input logic [31:0] v, input logic [3:0] b);
        for (int k = 0; k < 4; k++)
            if (b[k]) o[k*8 +: 8] = v[k*8 +: 8];
        return o;
    endfunction
    function automatic logic hit(input logic [31:0] t, input logic [31:0] c);
        logic own;
        own = t[TAG_SUP_BIT] || t[TAG_CTX_HI:TAG_CTX_LO] == context_i;
        if (md[FLUSH_CTX_BIT])
            own = !t[TAG_SUP_BIT] && t[TAG_CTX_HI:TAG_CTX_LO] == context_i;
        else if (md[FLUSH_PAGE_BIT])
            own = own && t[27:14] == c[27:14];
        else
            own = own && t[27:17] == c[27:17];
        return t[TAG_VALID_BIT] && own;
    endfunction
    function automatic logic [31:0] xl(input logic [31:0] v);
        return {4'h0, v[27:0] ^ 28'h010_0000};
    endfunction
    initial begin
        seed = 32'h6f4f_7765;
        {fails, checks, cycles, acks, wrs, rds, accs, mods, errs} = 0;
        {srst_i, ce_i} = 2'h3;
        {cyc_i, we_i, bad, fc_i, be_i, context_i, dly} = 15'h0000;
        addr_i = 32'h0000_0000;
        wdata_i = 32'h0000_0000;
        repeat (2) @(posedge mclk_i);
        #10 srst_i = 1'h0;
        check({ack_o, xlat_req_o, mem_req_o, wb_err_o}, 32'h0000_0000);
        for (i = 0; i < 8; i++) begin
            a = $random(seed);
            x = $random(seed);
            y = $random(seed);
            bus(1'h1, {OP_TAG, 14'h0000, a[13:4], 4'h0}, x, 4'hF);
            bus(1'h0, {OP_TAG, 14'h0000, a[13:4], 4'h0}, x, 4'hF);
            check(rd & TMASK, x & TMASK);
            bus(1'h1, {OP_DATA, 14'h0000, a[13:2], 2'h0}, x, 4'hF);
            bus(1'h1, {OP_DATA, 14'h0000, a[13:2], 2'h0}, y, a[3:0]);
            bus(1'h0, {OP_DATA, 14'h0000, a[13:2], 2'h0}, y, 4'hF);
            check(rd, merge(x, y, a[3:0]));
        end
        $display("tag and data access done");
        n = acks;
        {fc_i, cyc_i} = 4'h3;
        repeat (12) @(posedge mclk_i);
        #10 cyc_i = 1'h0;
        check(acks - n, 0);
        bus(1'h1, 32'h0000_0000, 32'h0000_0000, 4'hF);
        $display("refused cycles done");
        for (i = 0; i < 4; i++) begin
            ca = $random(seed);
            ca = {OP_FLUSH, ca[27:8], 8'h00};
            context_i = $random(seed);
            dly = $random(seed);
            md = (i == 3) ? 4'h2 : 4'h1 << i;
            bad = i == 3;
            ew = 0;
            for (n = 0; n < 16; n++) begin
                x = $random(seed);
                tg[n] = $random(seed);
                if (x[0]) tg[n][27:14] = ca[27:14];
                if (x[1]) tg[n][10:8] = context_i;
                bus(1'h1, {OP_TAG, 14'h0000, ca[13:8], n[3:0], 4'h0}, tg[n],
                    4'hF);
                if (hit(tg[n], ca) && tg[n][TAG_MOD_BIT]) ew = ew + 1;
            end
            {w0, e0, a0} = {wrs, errs, accs + mods};
            bus(1'h1, ca, {28'h000_0000, md}, 4'hF);
            check(wrs - w0, bad ? 0 : ew);
            check(errs - e0, bad ? ew : 0);
            check(accs + mods, a0);
            for (n = 0; n < 16; n++) begin
                bus(1'h0, {OP_TAG, 14'h0000, ca[13:8], n[3:0], 4'h0}, 0, 4'hF);
                hm = hit(tg[n], ca);
                y = hm ? 0 : tg[n] & TMASK;
                check(rd & TMASK, y);
            end
        end
        bad = 1'h0;
        $display("flush tests done");
        ca = $random(seed);
        da = $random(seed);
        {ca[3:0], da[3:0]} = 8'h00;
        bus(1'h1, {OP_TAG, 14'h0000, ca[13:4], 4'h0}, 0, 4'hF);
        {w0, r0, e0, a0, m0} = {wrs, rds, errs, accs, mods};
        bus(1'h0, {OP_COPY_RD, ca[27:0]}, 0, 4'hF);
        check(accs - a0, 1);
        check(mods - m0, 0);
        bus(1'h1, {OP_COPY_WR, da[27:0]}, 0, 4'hF);
        check(rd_addr, xl(ca));
        check(wr_addr, xl(da));
        check(wrs - w0, 1);
        check(rds - r0, 1);
        check(accs - a0, 2);
        check(mods - m0, 1);
        check(errs - e0, 0);
        $display("block copy done");
        tally_and_finish;
    end
endmodule
